// [include/rtc_params.svh]
// Constants for the terminal configuration bank: offsets, bit positions,
// reset value and time-out figures.
// Assumes inclusion by bare name from the configuration bank module.
`ifndef RTC_PARAMS_SVH
`define RTC_PARAMS_SVH

// Register map
`define RTC_CFG_OFFSET 16'h0017
`define RTC_CFG_RESET 16'h0000
`define RTC_UNMAPPED_READ 16'h0000

// Field positions inside the configuration word
`define RTC_TOSEL_HI 15
`define RTC_TOSEL_LO 14
`define RTC_INHA_BIT 13
`define RTC_INHB_BIT 12

// No-response time-outs in microseconds, per selector code
`define RTC_TO_00_US 57
`define RTC_TO_01_US 62
`define RTC_TO_10_US 122
`define RTC_TO_11_US 180

// Bus dead times in microseconds, per selector code
`define RTC_DEAD_00_US 15
`define RTC_DEAD_01_US 20
`define RTC_DEAD_10_US 80
`define RTC_DEAD_11_US 138

// Each embedded word inside the span, microseconds
`define RTC_EMBED_WORD_US 20

// System clock rate in MHz, cycles per microsecond
`define RTC_CLK_MHZ 250

// Timer width, wide enough for the longest time-out
`define RTC_TMR_W 16

`endif

// [include/rtc_pkg.sv]
// Types shared by the configuration bank and its time-out timer.
// Assumes the constants header sits on the include path.
package rtc_pkg;

    // Selector codes for the RT-to-RT time-out
    typedef enum logic [1:0]
    {
        RTC_TO_57 = 2'b00,
        RTC_TO_62 = 2'b01,
        RTC_TO_122 = 2'b10,
        RTC_TO_180 = 2'b11
    } rtc_tosel_t;

    // Timer states
    typedef enum logic [0:0]
    {
        RTC_TMR_IDLE = 1'b0,
        RTC_TMR_WAIT = 1'b1
    } rtc_tmr_state_t;

    // Per-bus inhibit pair
    typedef struct packed
    {
        logic tx;
        logic rx;
    } rtc_inhibit_t;

endpackage

// [include/rtc_timer_if.sv]
// Control link between the configuration bank and the time-out timer.
// Both ends run on the same system clock.
`timescale 1ns/1ps
interface rtc_timer_if #(
    parameter int CW = 16
);
    logic start; // Pulse: mid-parity of RT-RT receive command
    logic sync; // Pulse: mid-sync of first data word
    logic [CW-1:0] limit; // Time-out in cycles
    logic expired; // Pulse: no data word in time
    logic running; // Timer armed

    modport ctrl (output start, output sync, output limit,
                  input expired, input running);
    modport tmr (input start, input sync, input limit,
                 output expired, output running);
endinterface

// [hw/rtc_timeout_timer.sv]
// No-response timer for RT-to-RT receive commands.
// Assumes start and sync are one-cycle pulses on the system clock.
`timescale 1ns/1ps
module rtc_timeout_timer #(
    parameter int CW = 16
) (
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic ce_i,
    rtc_timer_if.tmr tif
);
    import rtc_pkg::*;

    rtc_tmr_state_t state_q, state_d; // Armed or idle
    logic [CW-1:0] count_q, count_d; // Cycles left before expiry
    logic expired_q, expired_d; // Registered expiry pulse

    // Next state; the limit is taken once so a selector change mid-message
    // cannot stretch or cut the running span
    always_comb
    begin
        state_d = state_q;
        count_d = count_q;
        expired_d = 1'b0;
        if (tif.start)
        begin
            // Fresh receive command restarts the span
            state_d = RTC_TMR_WAIT;
            count_d = tif.limit - {{(CW-1){1'b0}}, 1'b1};
        end
        else
        begin
            unique case (state_q)
                RTC_TMR_IDLE:
                begin
                    count_d = count_q;
                end
                RTC_TMR_WAIT:
                begin
                    if (tif.sync)
                    begin
                        // Data word arrived in time
                        state_d = RTC_TMR_IDLE;
                    end
                    else if (count_q == '0)
                    begin
                        state_d = RTC_TMR_IDLE;
                        expired_d = 1'b1;
                    end
                    else
                    begin
                        count_d = count_q - {{(CW-1){1'b0}}, 1'b1};
                    end
                end
            endcase
        end
    end

    // Registers; clock enable freezes everything
    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i)
        begin
            state_q <= RTC_TMR_IDLE;
            count_q <= '0;
            expired_q <= 1'b0;
        end
        else if (ce_i)
        begin
            state_q <= state_d;
            count_q <= count_d;
            expired_q <= expired_d;
        end
    end

    assign tif.running = (state_q == RTC_TMR_WAIT);
    assign tif.expired = expired_q;

    // Embedded words do not restart the count
    a_count_no_restart: assert property (@(posedge clk_sys_i)
        disable iff (reset_i)
        (ce_i && tif.running && !tif.start && !tif.sync && count_q != '0)
        |=> (count_q == $past(count_q) - {{(CW-1){1'b0}}, 1'b1}))
        else $error("timer count did not step down");

    a_sync_no_expiry: assert property (@(posedge clk_sys_i)
        disable iff (reset_i)
        (ce_i && tif.running && tif.sync && !tif.start)
        |=> (!tif.running && !tif.expired))
        else $error("sync did not stop the timer");

endmodule // rtc_timeout_timer

// [hw/rtc_bus_timeout_inhibit_cfg.sv]
// Upper configuration bits of the remote terminal: RT-to-RT time-out
// select and per-bus inhibit, plus the time-out supervisor.
// Assumes the host port decoder presents single-cycle register strobes
// on the system clock; protocol decoder supplies mid-bit event pulses.
//
// Behaviour
// - Selector codes map to 57/62/122/180 us.
// - Time from command mid-parity to data mid-sync.
// - Embedded command and status fall inside span.
// - Bus B inhibit bit inhibits per scope.
// - Scope chooses tx+rx or tx-only inhibit.
// - Bus B clear unless terminal bit, pin or master bit.
// - Bus A inhibit works the same way.
// - Fields read/write, reset to zero.
`timescale 1ns/1ps
`include "rtc_params.svh"
module rtc_bus_timeout_inhibit_cfg #(
    parameter logic [15:0] TO_CYC_0 = 16'(`RTC_TO_00_US * `RTC_CLK_MHZ),
    parameter logic [15:0] TO_CYC_1 = 16'(`RTC_TO_01_US * `RTC_CLK_MHZ),
    parameter logic [15:0] TO_CYC_2 = 16'(`RTC_TO_10_US * `RTC_CLK_MHZ),
    parameter logic [15:0] TO_CYC_3 = 16'(`RTC_TO_11_US * `RTC_CLK_MHZ)
) (
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic ce_i,
    // Register access
    input wire logic [15:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [15:0] reg_wdata_i,
    output logic [15:0] reg_rdata_o,
    // Master-level settings, same clock
    input wire logic inhibit_scope_select_i,
    input wire logic master_bus_a_inhibit_i,
    input wire logic master_bus_b_inhibit_i,
    // Device pins, asynchronous
    input wire logic bus_a_transmit_inhibit_pin_i,
    input wire logic bus_b_transmit_inhibit_pin_i,
    // Protocol events
    input wire logic rt_rt_receive_i,
    input wire logic cmd_parity_mid_i,
    input wire logic data_sync_mid_i,
    // Results
    output rtc_pkg::rtc_inhibit_t bus_a_inhibit_o,
    output rtc_pkg::rtc_inhibit_t bus_b_inhibit_o,
    output logic rt_rt_timeout_o
);
    import rtc_pkg::*;

    // Stored configuration fields
    rtc_tosel_t tosel_q, tosel_d; // Time-out selector
    logic inha_q, inha_d; // Terminal bus A inhibit
    logic inhb_q, inhb_d; // Terminal bus B inhibit
    logic [15:0] rdata_q, rdata_d; // Read data register
    logic [15:0] cfg_word; // Assembled word; other bits read zero
    logic cfg_hit; // Address decode

    // Inhibit outputs
    rtc_inhibit_t inh_a_q, inh_a_d;
    rtc_inhibit_t inh_b_q, inh_b_d;

    // Pin synchronisers
    logic pin_a_meta_q, pin_a_sync_q;
    logic pin_b_meta_q, pin_b_sync_q;

    // Global and combined inhibit requests
    logic glob_a, glob_b;
    logic req_a, req_b;

    // Time-out link
    logic [15:0] limit_w;
    rtc_timer_if #(.CW(`RTC_TMR_W)) tif ();

    assign cfg_hit = (reg_addr_i == `RTC_CFG_OFFSET);

    // Only the upper four bits exist here; lower bits read as zero
    always_comb
    begin
        cfg_word = `RTC_CFG_RESET;
        cfg_word[`RTC_TOSEL_HI:`RTC_TOSEL_LO] = tosel_q;
        cfg_word[`RTC_INHA_BIT] = inha_q;
        cfg_word[`RTC_INHB_BIT] = inhb_q;
    end

    // Register write and read next values
    always_comb
    begin
        tosel_d = tosel_q;
        inha_d = inha_q;
        inhb_d = inhb_q;
        rdata_d = rdata_q;
        if (reg_wr_i && cfg_hit)
        begin
            // Host write of the fields
            tosel_d = rtc_tosel_t'(reg_wdata_i[`RTC_TOSEL_HI:`RTC_TOSEL_LO]);
            inha_d = reg_wdata_i[`RTC_INHA_BIT];
            inhb_d = reg_wdata_i[`RTC_INHB_BIT];
        end
        if (reg_rd_i)
        begin
            // Unmapped addresses answer zero
            rdata_d = cfg_hit ? cfg_word : `RTC_UNMAPPED_READ;
        end
    end

    // Configuration registers, zero after reset
    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i)
        begin
            tosel_q <= RTC_TO_57;
            inha_q <= 1'b0;
            inhb_q <= 1'b0;
            rdata_q <= `RTC_CFG_RESET;
        end
        else if (ce_i)
        begin
            tosel_q <= tosel_d;
            inha_q <= inha_d;
            inhb_q <= inhb_d;
            rdata_q <= rdata_d;
        end
    end

    // Two-stage synchronisers for the inhibit pins
    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i)
        begin
            pin_a_meta_q <= 1'b0;
            pin_a_sync_q <= 1'b0;
            pin_b_meta_q <= 1'b0;
            pin_b_sync_q <= 1'b0;
        end
        else if (ce_i)
        begin
            pin_a_meta_q <= bus_a_transmit_inhibit_pin_i;
            pin_a_sync_q <= pin_a_meta_q;
            pin_b_meta_q <= bus_b_transmit_inhibit_pin_i;
            pin_b_sync_q <= pin_b_meta_q;
        end
    end

    // Inhibit decision; scope low blocks both ways, high transmit only.
    // Global sources follow the same scope as the terminal bit.
    always_comb
    begin
        glob_a = pin_a_sync_q || master_bus_a_inhibit_i;
        glob_b = pin_b_sync_q || master_bus_b_inhibit_i;
        req_a = inha_q || glob_a;
        req_b = inhb_q || glob_b;
        inh_a_d.tx = req_a;
        inh_a_d.rx = req_a && !inhibit_scope_select_i;
        inh_b_d.tx = req_b;
        inh_b_d.rx = req_b && !inhibit_scope_select_i;
    end

    // Registered inhibit outputs
    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i)
        begin
            inh_a_q <= '0;
            inh_b_q <= '0;
        end
        else if (ce_i)
        begin
            inh_a_q <= inh_a_d;
            inh_b_q <= inh_b_d;
        end
    end

    // Selector decode into cycles
    always_comb
    begin
        unique case (tosel_q)
            RTC_TO_57: limit_w = TO_CYC_0;
            RTC_TO_62: limit_w = TO_CYC_1;
            RTC_TO_122: limit_w = TO_CYC_2;
            RTC_TO_180: limit_w = TO_CYC_3;
        endcase
    end

    // Span opens at receive-command mid-parity only; the embedded transmit
    // command and the status word are not restart points, so their 20 us
    // each stay inside the span
    assign tif.start = rt_rt_receive_i && cmd_parity_mid_i;
    assign tif.sync = data_sync_mid_i;
    assign tif.limit = limit_w;

    rtc_timeout_timer #(.CW(`RTC_TMR_W)) u_timer (
        .clk_sys_i(clk_sys_i),
        .reset_i(reset_i),
        .ce_i(ce_i),
        .tif(tif)
    );

    // Expiry pulse tells the receiver to drop the message, no status
    assign rt_rt_timeout_o = tif.expired;
    assign reg_rdata_o = rdata_q;
    assign bus_a_inhibit_o = inh_a_q;
    assign bus_b_inhibit_o = inh_b_q;

    // Checks
    a_tosel_decode: assert property (@(posedge clk_sys_i)
        disable iff (reset_i)
        (tosel_q == RTC_TO_180) |-> (limit_w == TO_CYC_3))
        else $error("selector 11 gave wrong limit");

    a_start_parity: assert property (@(posedge clk_sys_i)
        disable iff (reset_i)
        (ce_i && rt_rt_receive_i && cmd_parity_mid_i) |=> tif.running)
        else $error("timer not armed at mid-parity");

    a_inhb_scope: assert property (@(posedge clk_sys_i)
        disable iff (reset_i)
        (ce_i && inhb_q) |=> (bus_b_inhibit_o.tx &&
        (bus_b_inhibit_o.rx == !$past(inhibit_scope_select_i))))
        else $error("bus B inhibit not per scope");

    a_scope_txonly: assert property (@(posedge clk_sys_i)
        disable iff (reset_i)
        (ce_i && inhibit_scope_select_i) |=> !bus_a_inhibit_o.rx)
        else $error("tx-only scope blocked receive");

    a_inhb_clear: assert property (@(posedge clk_sys_i)
        disable iff (reset_i)
        (ce_i && !inhb_q && !pin_b_sync_q && !master_bus_b_inhibit_i)
        |=> (bus_b_inhibit_o == '0))
        else $error("bus B inhibited with no source");

    a_inha_follow: assert property (@(posedge clk_sys_i)
        disable iff (reset_i)
        ce_i |=> (bus_a_inhibit_o.tx ==
        $past(inha_q || pin_a_sync_q || master_bus_a_inhibit_i)))
        else $error("bus A inhibit wrong");

    a_write_back: assert property (@(posedge clk_sys_i)
        disable iff (reset_i)
        (ce_i && reg_wr_i && cfg_hit && !reg_rd_i) ##1
        (ce_i && reg_rd_i && cfg_hit && !reg_wr_i)
        |=> (reg_rdata_o[`RTC_TOSEL_HI:`RTC_INHB_BIT] ==
        $past(reg_wdata_i[`RTC_TOSEL_HI:`RTC_INHB_BIT], 2)))
        else $error("written fields not read back");

    a_reset_zero: assert property (@(posedge clk_sys_i)
        reset_i |=> (cfg_word == `RTC_CFG_RESET && !rt_rt_timeout_o))
        else $error("config not zero after reset");

    a_timeout_pulse: assert property (@(posedge clk_sys_i)
        disable iff (reset_i)
        rt_rt_timeout_o |-> !tif.running ##1 !rt_rt_timeout_o)
        else $error("time-out not a single pulse");

endmodule // rtc_bus_timeout_inhibit_cfg

// [testbench/rtc_far_end.sv]
// Far-side model: a bus controller issuing RT-RT receive commands.
// Assumes the bench clock; the model's pulses change at the falling edge.
`timescale 1ns/1ps
module rtc_far_end (
    input wire logic clk_i,
    output logic rt_rt_o,
    output logic parity_mid_o,
    output logic sync_mid_o
);
    // Idle bus: no command, no data word
    initial
    begin
        rt_rt_o = 1'b0;
        parity_mid_o = 1'b0;
        sync_mid_o = 1'b0;
    end

    // One receive command; gap 0 means the data word never comes,
    // otherwise its mid-sync lands gap edges after the mid-parity edge
    task automatic send(input logic rtrt, input int gap);
        @(negedge clk_i);
        rt_rt_o = rtrt;
        parity_mid_o = 1'b1;
        @(negedge clk_i);
        parity_mid_o = 1'b0;
        if (gap > 0)
        begin
            repeat (gap - 1) @(negedge clk_i);
            sync_mid_o = 1'b1;
            @(negedge clk_i);
            sync_mid_o = 1'b0;
        end
        rt_rt_o = 1'b0;
    endtask
endmodule // rtc_far_end

// [testbench/rtc_bus_timeout_inhibit_cfg_bench.sv]
// Self-checking bench for the terminal configuration bank.
// Assumes shortened time-outs of 5, 6, 7 and 8 cycles per selector code.
`timescale 1ns/1ps
module rtc_bus_timeout_inhibit_cfg_bench;
    import rtc_pkg::*;
    localparam logic [15:0] CFG = 16'h0017;
    // One ordinary case: write data and scope beside expected results
    typedef struct
    {
        logic [15:0] wdata;
        logic scope;
        logic [15:0] rdata;
        logic [1:0] a;
        logic [1:0] b;
    } rtc_row_t;
    rtc_row_t rows [5] = '{
        '{16'hffff, 1'b0, 16'hf000, 2'h3, 2'h3},
        '{16'h2abc, 1'b1, 16'h2000, 2'h2, 2'h0},
        '{16'h1000, 1'b0, 16'h1000, 2'h0, 2'h3},
        '{16'h4000, 1'b1, 16'h4000, 2'h0, 2'h0},
        '{16'hb000, 1'b1, 16'hb000, 2'h2, 2'h2}};
    logic clk_sys_i = 1'b0;
    logic reset_i = 1'b1;
    logic ce_i = 1'b1; // Lowered once to check the freeze
    logic [15:0] addr = 16'h0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [15:0] wdata = 16'h0000;
    logic [15:0] rdata;
    logic scope = 1'b0;
    logic mst_a = 1'b0;
    logic mst_b = 1'b0;
    logic pin_a = 1'b0;
    logic pin_b = 1'b0;
    logic rtrt;
    logic par_mid;
    logic sync_mid;
    rtc_inhibit_t a_o;
    rtc_inhibit_t b_o;
    logic tmo;
    int num_errors = 0;
    int checks_done = 0;
    int cycles = 0;
    logic [15:0] d;
    int first;
    int hits;
    logic [3:0] src;

    // 250 MHz system clock
    always #2 clk_sys_i = ~clk_sys_i;

    rtc_bus_timeout_inhibit_cfg #(.TO_CYC_0(16'h0005), .TO_CYC_1(16'h0006),
        .TO_CYC_2(16'h0007), .TO_CYC_3(16'h0008)) uut (
        .clk_sys_i(clk_sys_i), .reset_i(reset_i), .ce_i(ce_i),
        .reg_addr_i(addr), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_wdata_i(wdata), .reg_rdata_o(rdata),
        .inhibit_scope_select_i(scope),
        .master_bus_a_inhibit_i(mst_a), .master_bus_b_inhibit_i(mst_b),
        .bus_a_transmit_inhibit_pin_i(pin_a),
        .bus_b_transmit_inhibit_pin_i(pin_b),
        .rt_rt_receive_i(rtrt), .cmd_parity_mid_i(par_mid),
        .data_sync_mid_i(sync_mid), .bus_a_inhibit_o(a_o),
        .bus_b_inhibit_o(b_o), .rt_rt_timeout_o(tmo));

    rtc_far_end far (.clk_i(clk_sys_i), .rt_rt_o(rtrt),
        .parity_mid_o(par_mid), .sync_mid_o(sync_mid));

    // Verdict and end of run, the single exit point
    task automatic complete_run();
        if (num_errors == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Compare and report at once
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            num_errors++;
            $display("unexpected t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // One-cycle write strobe
    task automatic reg_write(input logic [15:0] a, input logic [15:0] v);
        @(negedge clk_sys_i);
        addr = a;
        wdata = v;
        wr = 1'b1;
        @(negedge clk_sys_i);
        wr = 1'b0;
    endtask

    // One-cycle read strobe; data is registered at the taking edge
    task automatic reg_read(input logic [15:0] a, output logic [15:0] v);
        @(negedge clk_sys_i);
        addr = a;
        rd = 1'b1;
        @(negedge clk_sys_i);
        rd = 1'b0;
        v = rdata;
    endtask

    // Run one command and log when, and how often, the time-out pulses
    task automatic measure(input logic rt, input int gap,
                           output int f, output int h);
        f = 0;
        h = 0;
        fork
            far.send(rt, gap);
            begin
                repeat (2) @(negedge clk_sys_i);
                for (int k = 1; k <= 12; k++)
                begin
                    @(negedge clk_sys_i);
                    if (tmo === 1'b1)
                    begin
                        h++;
                        if (f == 0)
                            f = k;
                    end
                end
            end
        join
    endtask

    // Hang guard, well above the expected run length
    always @(posedge clk_sys_i)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            num_errors++;
            complete_run();
        end
    end

    // Main sequence
    initial
    begin
        repeat (10) @(negedge clk_sys_i);
        reset_i = 1'b0;
        reg_read(CFG, d);
        chk(d, 16'h0000);
        chk({12'h0, a_o, b_o}, 16'h0000);
        // Ordinary cases from the table
        for (int i = 0; i < 5; i++)
        begin
            scope = rows[i].scope;
            reg_write(CFG, rows[i].wdata);
            reg_read(CFG, d);
            chk(d, rows[i].rdata);
            repeat (2) @(negedge clk_sys_i);
            chk({14'h0, a_o}, {14'h0, rows[i].a});
            chk({14'h0, b_o}, {14'h0, rows[i].b});
        end
        // Global sources, one at a time, with terminal bits clear
        scope = 1'b0;
        reg_write(CFG, 16'h0000);
        for (int j = 0; j < 4; j++)
        begin
            src = 4'h1 << j;
            pin_a = src[0];
            pin_b = src[1];
            mst_a = src[2];
            mst_b = src[3];
            repeat (5) @(negedge clk_sys_i);
            chk({14'h0, a_o}, (src[0] | src[2]) ? 16'h0003 : 16'h0000);
            chk({14'h0, b_o}, (src[1] | src[3]) ? 16'h0003 : 16'h0000);
        end
        mst_b = 1'b0;
        repeat (3) @(negedge clk_sys_i);
        chk({12'h0, a_o, b_o}, 16'h0000);
        // Unmapped place: write ignored, reads zero
        reg_write(16'h0016, 16'hffff);
        reg_read(16'h0016, d);
        chk(d, 16'h0000);
        reg_read(CFG, d);
        chk(d, 16'h0000);
        // Every selector code: expiry, a data word on the last edge,
        // and one a cycle too late
        for (int s = 0; s < 4; s++)
        begin
            reg_write(CFG, {2'(s), 14'h0});
            measure(1'b1, 0, first, hits);
            chk(16'(first), 16'(5 + s));
            chk(16'(hits), 16'h0001);
            measure(1'b1, 5 + s, first, hits);
            chk(16'(hits), 16'h0000);
            measure(1'b1, 6 + s, first, hits);
            chk(16'(first), 16'(5 + s));
            chk(16'(hits), 16'h0001);
        end
        // Not an RT-RT command: no supervision
        measure(1'b0, 0, first, hits);
        chk(16'(hits), 16'h0000);
        // Clock enable low: a write strobe is frozen out
        ce_i = 1'b0;
        reg_write(CFG, 16'h1000);
        ce_i = 1'b1;
        reg_read(CFG, d);
        chk(d, 16'hc000);
        // Reset in mid-run returns the fields to zero
        reg_write(CFG, 16'hf000);
        @(negedge clk_sys_i);
        reset_i = 1'b1;
        repeat (3) @(negedge clk_sys_i);
        reset_i = 1'b0;
        reg_read(CFG, d);
        chk(d, 16'h0000);
        complete_run();
    end
endmodule // rtc_bus_timeout_inhibit_cfg_bench
